// file: design/rscp_defs.vh
// Constants for the reader serial command parser
`ifndef RSCP_DEFS_VH
`define RSCP_DEFS_VH

// ----------------------------------------
// Framing characters
// ----------------------------------------
`define RSCP_CH_BANG 8'h21
`define RSCP_CH_COMMA 8'h2C
`define RSCP_CH_EQ 8'h3D
`define RSCP_CH_CR 8'h0D
`define RSCP_CH_LF 8'h0A
`define RSCP_CH_ZERO 8'h30

// ----------------------------------------
// Command names as ASCII, first char in the top byte
// ----------------------------------------
`define RSCP_NAME_MAX 4'hB
`define RSCP_NM_TRIG 56'h54524947474552
`define RSCP_LEN_TRIG 4'h7
`define RSCP_NM_RUN 24'h52554E
`define RSCP_LEN_RUN 4'h3
`define RSCP_NM_SETUP 40'h5345545550
`define RSCP_LEN_SETUP 4'h5
`define RSCP_NM_OFF 56'h4F46464C494E45
`define RSCP_LEN_OFF 4'h7
`define RSCP_NM_EXP 88'h5345545845504F53555245
`define RSCP_LEN_EXP 4'hB
`define RSCP_NM_GAIN 56'h5345544741494E
`define RSCP_LEN_GAIN 4'h7

// ----------------------------------------
// Operating modes and their reset value
// ----------------------------------------
`define RSCP_MODE_RUN 2'h0
`define RSCP_MODE_SETUP 2'h1
`define RSCP_MODE_OFF 2'h2
`define RSCP_MODE_RST 2'h0

// ----------------------------------------
// Response codes
// ----------------------------------------
`define RSCP_ERR_OK 7'h00
`define RSCP_ERR_NOJOB 7'h01
`define RSCP_ERR_CAP 7'h02
`define RSCP_ERR_RANGE 7'h03
`define RSCP_ERR_MODE 7'h04
`define RSCP_ERR_FMT 7'h65

`endif

// file: design/rscp_parser.v
// Text command parser: framing, mode control, soft trigger, capture settings, echo
`timescale 1ns/100ps
`include "rscp_defs.vh"

// Function
// R1: A command is '!' plus name, ended by CR; nothing else is recognised.
// R2: Commas separate the name from the first argument and arguments from each other.
// R3: Reply is '!', name, '=', decimal code, CR, LF; zero means success.
// R4: Host waits up to five seconds for slow set-up replies.
// R5: Trigger acts only in run or setup; ack first, read cycle afterwards.
// R6: Run mode allows job change, refuses parameter changes.
// R7: Setup mode refuses job change, allows parameter changes.
// R8: Offline stops the job, ignores triggers, allows job change, refuses parameters.
// R9: Mode and trigger commands take no arguments and always answer zero.
// R10: Exposure command writes value two into capture named by one-based argument one.
// R11: Gain command writes value two into capture named by one-based argument one.
// R12: Setting commands answer 1 no job, 2 bad capture, 3 range, 101 format.
// R13: Commands arrive on the same channels that carry result data.
// R14: Reply goes back on the command's channel; one command at a time.
module rscp_parser #(
    parameter NUM_CAPTURES = 8,
    parameter [15:0] EXP_MAX = 16'h2710,
    parameter [15:0] GAIN_MAX = 16'h0064,
    parameter CHAN_W = 2
)(
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_rx_valid,
    input wire [7:0] i_rx_data,
    input wire [CHAN_W-1:0] i_rx_chan,
    output reg o_rx_ready,
    output reg o_tx_valid,
    output reg [7:0] o_tx_data,
    output reg [CHAN_W-1:0] o_tx_chan,
    input wire i_tx_ready,
    input wire i_job_loaded,
    output reg [1:0] o_mode,
    output reg o_job_change_ok,
    output reg o_param_change_ok,
    output reg o_read_start,
    output reg o_param_we,
    output reg o_param_is_gain,
    output reg [7:0] o_param_cap,
    output reg [15:0] o_param_val
);

    // ----------------------------------------
    // States and commands
    // ----------------------------------------
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_NAME = 3'h1;
    localparam [2:0] S_ARG = 3'h2;
    localparam [2:0] S_EXEC = 3'h3;
    localparam [2:0] S_TX = 3'h4;

    localparam [2:0] C_NONE = 3'h0;
    localparam [2:0] C_TRIG = 3'h1;
    localparam [2:0] C_RUN = 3'h2;
    localparam [2:0] C_SETUP = 3'h3;
    localparam [2:0] C_OFF = 3'h4;
    localparam [2:0] C_EXP = 3'h5;
    localparam [2:0] C_GAIN = 3'h6;

    reg [2:0] state_r;
    reg [CHAN_W-1:0] chan_r;
    reg [87:0] name_r;
    reg [3:0] len_r;
    reg name_ovf_r;
    reg [1:0] arg_cnt_r;
    reg [15:0] arg1_r;
    reg [15:0] arg2_r;
    reg arg1_ovf_r;
    reg arg2_ovf_r;
    reg fmt_err_r;
    reg trig_pend_r;
    reg [4:0] tx_step_r;
    reg [1:0] ndig_r;
    reg [3:0] dig0_r;
    reg [3:0] dig1_r;
    reg [3:0] dig2_r;

    wire rx_take;
    wire same_chan;
    wire is_digit;
    reg [2:0] cmd;
    reg [6:0] code;
    reg [7:0] tx_byte;
    reg [4:0] tx_total;

    // Bytes come from the link stack on this clock, so no synchroniser
    assign rx_take = i_rx_valid & o_rx_ready;
    assign same_chan = (i_rx_chan == chan_r);
    assign is_digit = (i_rx_data >= 8'h30) && (i_rx_data <= 8'h39);

    // ----------------------------------------
    // Decimal accumulation of the current argument
    // ----------------------------------------
    wire [15:0] acc_cur = (arg_cnt_r == 2'h1) ? arg1_r : arg2_r;
    wire [19:0] acc_prod = {4'h0, acc_cur} * 20'h0000A + {16'h0000, i_rx_data[3:0]};
    wire [16:0] acc_nxt = {(|acc_prod[19:16]), acc_prod[15:0]}; // Top bit flags overflow

    // ----------------------------------------
    // Name decode; lengths must match so a prefix never aliases
    // ----------------------------------------
    always @*
    begin
        cmd = C_NONE;
        if (name_ovf_r)
            cmd = C_NONE;
        else if (len_r == `RSCP_LEN_TRIG && name_r[55:0] == `RSCP_NM_TRIG)
            cmd = C_TRIG;
        else if (len_r == `RSCP_LEN_RUN && name_r[23:0] == `RSCP_NM_RUN)
            cmd = C_RUN;
        else if (len_r == `RSCP_LEN_SETUP && name_r[39:0] == `RSCP_NM_SETUP)
            cmd = C_SETUP;
        else if (len_r == `RSCP_LEN_OFF && name_r[55:0] == `RSCP_NM_OFF)
            cmd = C_OFF;
        else if (len_r == `RSCP_LEN_EXP && name_r == `RSCP_NM_EXP)
            cmd = C_EXP;
        else if (len_r == `RSCP_LEN_GAIN && name_r[55:0] == `RSCP_NM_GAIN)
            cmd = C_GAIN;
    end

    // ----------------------------------------
    // Answer code, checks taken in a fixed priority
    // ----------------------------------------
    always @*
    begin
        code = `RSCP_ERR_OK; // [R9]
        if (cmd == C_EXP || cmd == C_GAIN)
        begin
            if (arg_cnt_r < 2'h2 || fmt_err_r)
                code = `RSCP_ERR_FMT; // [R12]
            else if (!i_job_loaded)
                code = `RSCP_ERR_NOJOB; // [R12]
            else if (arg1_ovf_r || arg1_r == 16'h0000 || arg1_r > NUM_CAPTURES)
                code = `RSCP_ERR_CAP; // [R12]
            else if (arg2_ovf_r || arg2_r > ((cmd == C_EXP) ? EXP_MAX : GAIN_MAX))
                code = `RSCP_ERR_RANGE; // [R12]
            else if (o_mode != `RSCP_MODE_SETUP)
                code = `RSCP_ERR_MODE; // [R6] [R8]
        end
    end

    // Decimal digits of the code; quotients are cut to four bits on purpose
    wire [6:0] code_low = (code >= 7'h64) ? code - 7'h64 : code;
    wire [6:0] code_tens = code_low / 7'h0A;
    wire [6:0] code_ones = code_low % 7'h0A;
    wire [3:0] code_lead = (code >= 7'h64) ? 4'h1
        : ((code >= 7'h0A) ? code_tens[3:0] : code_ones[3:0]);

    // ----------------------------------------
    // Reply byte for the current step: '!' name '=' digits CR LF
    // ----------------------------------------
    always @*
    begin
        tx_total = {1'b0, len_r} + {3'h0, ndig_r} + 5'h04;
        tx_byte = `RSCP_CH_LF;
        if (tx_step_r == 5'h00)
            tx_byte = `RSCP_CH_BANG; // [R3]
        else if (tx_step_r <= {1'b0, len_r})
            tx_byte = name_r[8*(len_r - tx_step_r[3:0]) +: 8];
        else if (tx_step_r == {1'b0, len_r} + 5'h01)
            tx_byte = `RSCP_CH_EQ;
        else if (tx_step_r == {1'b0, len_r} + 5'h02)
            tx_byte = `RSCP_CH_ZERO + {4'h0, dig0_r};
        else if (tx_step_r <= {1'b0, len_r} + {3'h0, ndig_r} + 5'h01)
            tx_byte = `RSCP_CH_ZERO + {4'h0, (tx_step_r == {1'b0, len_r} + 5'h03) ? dig1_r : dig2_r};
        else if (tx_step_r == {1'b0, len_r} + {3'h0, ndig_r} + 5'h02)
            tx_byte = `RSCP_CH_CR;
    end

    // ----------------------------------------
    // Main sequencer
    // ----------------------------------------
    // Input stalls from frame end until the reply's LF goes: one command in flight, no buffer
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            state_r <= S_IDLE;
            chan_r <= {CHAN_W{1'b0}};
            name_r <= 88'h0;
            len_r <= 4'h0;
            name_ovf_r <= 1'b0;
            arg_cnt_r <= 2'h0;
            arg1_r <= 16'h0000;
            arg2_r <= 16'h0000;
            arg1_ovf_r <= 1'b0;
            arg2_ovf_r <= 1'b0;
            fmt_err_r <= 1'b0;
            trig_pend_r <= 1'b0;
            tx_step_r <= 5'h00;
            ndig_r <= 2'h1;
            dig0_r <= 4'h0;
            dig1_r <= 4'h0;
            dig2_r <= 4'h0;
            o_rx_ready <= 1'b1;
            o_tx_valid <= 1'b0;
            o_tx_data <= 8'h00;
            o_tx_chan <= {CHAN_W{1'b0}};
            o_mode <= `RSCP_MODE_RST;
            o_job_change_ok <= 1'b1;
            o_param_change_ok <= 1'b0;
            o_read_start <= 1'b0;
            o_param_we <= 1'b0;
            o_param_is_gain <= 1'b0;
            o_param_cap <= 8'h00;
            o_param_val <= 16'h0000;
        end
        else
        begin
            o_read_start <= 1'b0;
            o_param_we <= 1'b0;
            case (state_r)
                S_IDLE, S_NAME, S_ARG:
                begin
                    if (rx_take && (state_r == S_IDLE || same_chan || i_rx_data == `RSCP_CH_BANG))
                    begin
                        if (i_rx_data == `RSCP_CH_BANG)
                        begin
                            // A fresh '!' restarts framing on any channel [R1] [R13]
                            state_r <= S_NAME;
                            chan_r <= i_rx_chan;
                            name_r <= 88'h0;
                            len_r <= 4'h0;
                            name_ovf_r <= 1'b0;
                            arg_cnt_r <= 2'h0;
                            arg1_r <= 16'h0000;
                            arg2_r <= 16'h0000;
                            arg1_ovf_r <= 1'b0;
                            arg2_ovf_r <= 1'b0;
                            fmt_err_r <= 1'b0;
                        end
                        else if (state_r == S_IDLE)
                            state_r <= S_IDLE; // Text outside a frame is dropped [R1]
                        else if (i_rx_data == `RSCP_CH_CR)
                        begin
                            state_r <= S_EXEC; // [R1]
                            o_rx_ready <= 1'b0; // [R14]
                        end
                        else if (i_rx_data == `RSCP_CH_COMMA)
                        begin
                            state_r <= S_ARG; // [R2]
                            if (arg_cnt_r != 2'h3)
                                arg_cnt_r <= arg_cnt_r + 2'h1;
                        end
                        else if (state_r == S_NAME)
                        begin
                            if (len_r == `RSCP_NAME_MAX)
                                name_ovf_r <= 1'b1;
                            else
                            begin
                                name_r <= {name_r[79:0], i_rx_data};
                                len_r <= len_r + 4'h1;
                            end
                        end
                        else if (!is_digit)
                            fmt_err_r <= 1'b1;
                        else if (arg_cnt_r == 2'h1)
                        begin
                            arg1_r <= acc_nxt[15:0];
                            arg1_ovf_r <= arg1_ovf_r | acc_nxt[16];
                        end
                        else if (arg_cnt_r == 2'h2)
                        begin
                            arg2_r <= acc_nxt[15:0];
                            arg2_ovf_r <= arg2_ovf_r | acc_nxt[16];
                        end
                    end
                end
                S_EXEC:
                begin
                    if (cmd == C_NONE)
                    begin
                        // Unknown names get no reply and free the input
                        state_r <= S_IDLE;
                        o_rx_ready <= 1'b1;
                    end
                    else
                    begin
                        state_r <= S_TX;
                        tx_step_r <= 5'h00;
                        o_tx_chan <= chan_r; // [R14]
                        ndig_r <= (code >= 7'h64) ? 2'h3 : ((code >= 7'h0A) ? 2'h2 : 2'h1);
                        dig0_r <= code_lead;
                        dig1_r <= (code >= 7'h64) ? code_tens[3:0] : code_ones[3:0];
                        dig2_r <= code_ones[3:0];
                        // Trigger fires only from run or setup [R5] [R8]
                        trig_pend_r <= (cmd == C_TRIG) && (o_mode != `RSCP_MODE_OFF);
                        // A mode command sets the mode and both permission flags together
                        if (cmd == C_RUN || cmd == C_SETUP || cmd == C_OFF)
                        begin
                            o_mode <= (cmd == C_SETUP) ? `RSCP_MODE_SETUP // [R6] [R7] [R8]
                                : ((cmd == C_RUN) ? `RSCP_MODE_RUN : `RSCP_MODE_OFF);
                            o_job_change_ok <= (cmd != C_SETUP);
                            o_param_change_ok <= (cmd == C_SETUP);
                        end
                        if ((cmd == C_EXP || cmd == C_GAIN) && code == `RSCP_ERR_OK)
                        begin
                            o_param_we <= 1'b1; // [R10] [R11]
                            o_param_is_gain <= (cmd == C_GAIN);
                            o_param_cap <= arg1_r[7:0];
                            o_param_val <= arg2_r;
                        end
                    end
                end
                S_TX:
                begin
                    if (!o_tx_valid || i_tx_ready)
                    begin
                        if (tx_step_r == tx_total)
                        begin
                            // Read cycle only after the ack is fully handed off [R5]
                            o_tx_valid <= 1'b0;
                            o_read_start <= trig_pend_r;
                            trig_pend_r <= 1'b0;
                            state_r <= S_IDLE;
                            o_rx_ready <= 1'b1;
                        end
                        else
                        begin
                            o_tx_valid <= 1'b1;
                            o_tx_data <= tx_byte; // [R3]
                            tx_step_r <= tx_step_r + 5'h01;
                        end
                    end
                end
                default:
                begin
                    state_r <= S_IDLE;
                    o_rx_ready <= 1'b1;
                    o_tx_valid <= 1'b0;
                end
            endcase
        end
    end

endmodule

// file: sim/rscp_parser_checker.sv
// Concurrent checks on the command parser ports
`timescale 1ns/100ps
`include "rscp_defs.vh"
module rscp_parser_checker #(
    parameter NUM_CAPTURES = 8,
    parameter [15:0] EXP_MAX = 16'h2710,
    parameter [15:0] GAIN_MAX = 16'h0064
)(
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_tx_ready,
    input wire o_rx_ready,
    input wire o_tx_valid,
    input wire [7:0] o_tx_data,
    input wire [1:0] o_mode,
    input wire o_job_change_ok,
    input wire o_param_change_ok,
    input wire o_read_start,
    input wire o_param_we,
    input wire o_param_is_gain,
    input wire [7:0] o_param_cap,
    input wire [15:0] o_param_val
);
// ----------------------------------------
// Port relations
// ----------------------------------------
default clocking cb @(posedge i_clk); endclocking
default disable iff (i_sys_rst);
job_flag_a: assert property (o_job_change_ok == (o_mode != `RSCP_MODE_SETUP))
    else $error("job change flag wrong for mode");
param_flag_a: assert property (o_param_change_ok == (o_mode == `RSCP_MODE_SETUP))
    else $error("param change flag wrong for mode");
reply_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("reply byte moved before taken");
reply_start_a: assert property ($rose(o_tx_valid) |-> o_tx_data == `RSCP_CH_BANG)
    else $error("reply does not open with bang");
reply_end_a: assert property (o_tx_valid && i_tx_ready && o_tx_data == `RSCP_CH_LF
    |=> !o_tx_valid && o_rx_ready) else $error("reply end not followed by ready");
one_cmd_a: assert property (o_tx_valid |-> !o_rx_ready)
    else $error("input open while replying");
read_after_a: assert property (o_read_start |-> $fell(o_tx_valid) && o_mode != `RSCP_MODE_OFF ##1 !o_read_start)
    else $error("read start out of place");
write_ok_a: assert property (o_param_we |-> o_mode == `RSCP_MODE_SETUP && o_param_cap >= 8'h01
    && o_param_cap <= NUM_CAPTURES && o_param_val <= (o_param_is_gain ? GAIN_MAX : EXP_MAX)
    ##1 !o_param_we) else $error("bad capture write");
endmodule

bind rscp_parser rscp_parser_checker #(.NUM_CAPTURES(NUM_CAPTURES), .EXP_MAX(EXP_MAX),
    .GAIN_MAX(GAIN_MAX)) chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tx_ready(i_tx_ready),
    .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_mode(o_mode),
    .o_job_change_ok(o_job_change_ok), .o_param_change_ok(o_param_change_ok),
    .o_read_start(o_read_start), .o_param_we(o_param_we), .o_param_is_gain(o_param_is_gain),
    .o_param_cap(o_param_cap), .o_param_val(o_param_val));

// file: sim/rscp_host_model.sv
// Host model: sends command bytes on a channel and collects reply bytes
`timescale 1ns/100ps
module rscp_host_model (
    input wire i_clk,
    output reg o_cmd_valid,
    output reg [7:0] o_cmd_data,
    output reg [1:0] o_cmd_chan,
    input wire i_cmd_ready,
    input wire i_reply_valid,
    input wire [7:0] i_reply_data,
    input wire [1:0] i_reply_chan,
    output reg o_reply_ready
);
reg [7:0] rx_q[$];
reg [1:0] ch_q[$];
reg slow = 1'b0;
initial
begin
    o_cmd_valid = 1'b0;
    o_cmd_data = 8'h00;
    o_cmd_chan = 2'h0;
    o_reply_ready = 1'b1;
end
// Slow host is ready only every other cycle to stress the hold
always @(negedge i_clk)
    o_reply_ready <= slow ? ~o_reply_ready : 1'b1;
always @(posedge i_clk)
begin
    if (i_reply_valid && o_reply_ready)
    begin
        rx_q.push_back(i_reply_data);
        ch_q.push_back(i_reply_chan);
    end
end
// Byte held from a falling edge until a rising edge sees ready; ready read off-edge
task automatic send(input [7:0] b, input [1:0] ch);
    reg r;
    int n;
begin
    n = 0;
    @(negedge i_clk);
    o_cmd_valid = 1'b1;
    o_cmd_data = b;
    o_cmd_chan = ch;
    r = i_cmd_ready;
    @(posedge i_clk);
    while (!r && n < 200)
    begin
        @(negedge i_clk);
        r = i_cmd_ready;
        @(posedge i_clk);
        n++;
    end
end
endtask
// Released data shows the inverse so a stale byte never passes as fresh
task idle;
begin
    @(negedge i_clk);
    o_cmd_valid = 1'b0;
    o_cmd_data = ~o_cmd_data;
end
endtask
endmodule

// file: sim/tb.sv
// Self-checking bench for the command parser
`timescale 1ns/100ps
`include "rscp_defs.vh"
module tb;
reg clk = 1'b0;
reg rst = 1'b1;
reg job = 1'b1;
wire rv, rr, tv, tr, jok, pok, rd, we, isg;
wire [7:0] rdat, tdat, cap;
wire [1:0] rch, tch, mode;
wire [15:0] val;
int num_errors = 0;
int checks_done = 0;
int cyc = 0;
int rd_cnt = 0;
int we_cnt = 0;
always #4 clk = ~clk;
rscp_host_model host (.i_clk(clk), .o_cmd_valid(rv), .o_cmd_data(rdat), .o_cmd_chan(rch),
    .i_cmd_ready(rr), .i_reply_valid(tv), .i_reply_data(tdat), .i_reply_chan(tch),
    .o_reply_ready(tr));
rscp_parser uut (.i_clk(clk), .i_sys_rst(rst), .i_rx_valid(rv), .i_rx_data(rdat),
    .i_rx_chan(rch), .o_rx_ready(rr), .o_tx_valid(tv), .o_tx_data(tdat), .o_tx_chan(tch),
    .i_tx_ready(tr), .i_job_loaded(job), .o_mode(mode), .o_job_change_ok(jok),
    .o_param_change_ok(pok), .o_read_start(rd), .o_param_we(we), .o_param_is_gain(isg),
    .o_param_cap(cap), .o_param_val(val));
// ----------------------------------------
// Pulse counters and hang limit
// ----------------------------------------
always @(posedge clk)
begin
    cyc <= cyc + 1;
    rd_cnt <= rd_cnt + rd;
    we_cnt <= we_cnt + we;
    if (cyc == 20000)
    begin
        num_errors = num_errors + 1;
        report_and_stop;
    end
end
task check(input [15:0] seen, input [15:0] exp, input string what);
begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
        num_errors = num_errors + 1;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
end
endtask
task report_and_stop;
begin
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
end
endtask
// Send one framed command, then compare the whole echoed reply
task automatic do_cmd(input [87:0] nm, input [3:0] ln, input string a, input [6:0] code,
    input [1:0] ch);
    reg [7:0] e[$];
    int i;
begin
    host.rx_q.delete();
    host.ch_q.delete();
    e.push_back(`RSCP_CH_BANG);
    for (i = 0; i < ln; i++)
        e.push_back(nm[(ln - 1 - i) * 8 +: 8]);
    foreach (e[k])
        host.send(e[k], ch);
    for (i = 0; i < a.len(); i++)
        host.send(a[i], ch);
    host.send(`RSCP_CH_CR, ch);
    host.idle();
    e.push_back(`RSCP_CH_EQ);
    if (code >= 100)
        e.push_back(8'h30 + code / 100);
    if (code >= 10)
        e.push_back(8'h30 + (code / 10) % 10);
    e.push_back(8'h30 + code % 10);
    e.push_back(`RSCP_CH_CR);
    e.push_back(`RSCP_CH_LF);
    i = 0;
    while (host.rx_q.size() < e.size() && i < 400)
    begin
        @(posedge clk);
        i++;
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(host.rx_q.size(), e.size(), "reply length");
    foreach (e[k])
        check(host.rx_q[k], e[k], "reply byte");
    foreach (host.ch_q[k])
        check(host.ch_q[k], ch, "reply channel");
end
endtask
task automatic refuse(input [87:0] nm, input [3:0] ln, input string a, input [6:0] code);
    int n;
begin
    n = we_cnt;
    do_cmd(nm, ln, a, code, 2'h0);
    check(we_cnt, n, "write count");
end
endtask
task automatic mode_trig(input [87:0] nm, input [3:0] ln, input [1:0] md, input [1:0] ch);
    int n;
begin
    do_cmd(nm, ln, "", 7'h00, ch);
    check(mode, md, "mode");
    check(jok, md != `RSCP_MODE_SETUP, "job ok");
    check(pok, md == `RSCP_MODE_SETUP, "param ok");
    n = rd_cnt;
    do_cmd(`RSCP_NM_TRIG, `RSCP_LEN_TRIG, "", 7'h00, ch);
    check(rd_cnt, n + (md != `RSCP_MODE_OFF), "read starts");
    $display("test mode %0d done", md);
end
endtask
task t_params;
begin
    do_cmd(`RSCP_NM_GAIN, `RSCP_LEN_GAIN, ",1,50", 7'h00, 2'h1);
    check({isg, cap}, 16'h0101, "gain target");
    check(val, 16'h0032, "gain value");
    do_cmd(`RSCP_NM_EXP, `RSCP_LEN_EXP, ",8,10000", 7'h00, 2'h2);
    check({isg, cap}, 16'h0008, "exposure target");
    check(val, 16'h2710, "exposure value");
    check(we_cnt, 2, "write count");
    refuse(`RSCP_NM_GAIN, `RSCP_LEN_GAIN, ",1,101", `RSCP_ERR_RANGE);
    refuse(`RSCP_NM_EXP, `RSCP_LEN_EXP, ",1,10001", `RSCP_ERR_RANGE);
    refuse(`RSCP_NM_EXP, `RSCP_LEN_EXP, ",0,5", `RSCP_ERR_CAP);
    refuse(`RSCP_NM_GAIN, `RSCP_LEN_GAIN, ",9,5", `RSCP_ERR_CAP);
    refuse(`RSCP_NM_EXP, `RSCP_LEN_EXP, ",1", `RSCP_ERR_FMT);
    job = 1'b0;
    refuse(`RSCP_NM_GAIN, `RSCP_LEN_GAIN, ",1,5", `RSCP_ERR_NOJOB);
    job = 1'b1;
    do_cmd(`RSCP_NM_RUN, `RSCP_LEN_RUN, "", 7'h00, 2'h0);
    refuse(`RSCP_NM_EXP, `RSCP_LEN_EXP, ",1,5", `RSCP_ERR_MODE);
    $display("test settings done");
end
endtask
// Unknown name gets no reply and reopens input; a stray letter in an argument is a format error
task t_unknown;
begin
    host.rx_q.delete();
    host.send(`RSCP_CH_BANG, 2'h1);
    host.send(8'h51, 2'h1);
    host.send(`RSCP_CH_CR, 2'h1);
    host.idle();
    repeat (20) @(posedge clk);
    @(negedge clk);
    check(host.rx_q.size(), 0, "unknown reply");
    check(rr, 1'b1, "ready after unknown");
    refuse(`RSCP_NM_GAIN, `RSCP_LEN_GAIN, ",1,5x", `RSCP_ERR_FMT);
    $display("test unknown done");
end
endtask
// Main sequence: reset state, modes with triggers, settings, slow host with noise
initial
begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check({rr, tv, jok, pok, rd, we}, 16'h0028, "reset flags");
    check(mode, `RSCP_MODE_RUN, "reset mode");
    mode_trig(`RSCP_NM_RUN, `RSCP_LEN_RUN, `RSCP_MODE_RUN, 2'h0);
    mode_trig(`RSCP_NM_OFF, `RSCP_LEN_OFF, `RSCP_MODE_OFF, 2'h1);
    mode_trig(`RSCP_NM_SETUP, `RSCP_LEN_SETUP, `RSCP_MODE_SETUP, 2'h2);
    t_params;
    t_unknown;
    host.slow = 1'b1;
    host.send(8'h7A, 2'h3);
    host.send(`RSCP_CH_CR, 2'h3);
    mode_trig(`RSCP_NM_OFF, `RSCP_LEN_OFF, `RSCP_MODE_OFF, 2'h3);
    report_and_stop;
end
endmodule
